// ==== conv_defines.svh ====
// Purpose: Offsets, fields, resets and timing counts of the converter control
// Assumes: 25 MHz system clock, 8-bit registers on 32-bit Avalon words
// Notes: Definitions only
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

// Register byte addresses
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h4
`define OFS_RESULT_HIGH 4'h8
`define OFS_RESULT_LOW 4'hc
`define OFS_STATUS 4'h10
// Field positions
`define CA_ON_BIT 0
`define CA_GO_BIT 1
`define CA_CHS_LSB 2
`define CA_CHS_MSB 6
`define CB_REF_BIT 0
`define CB_CLK_LSB 4
`define CB_CLK_MSB 6
`define ST_FLAG_BIT 0
`define ST_IE_BIT 1
// Reset values
`define CONTROL_A_RST 8'h00
`define CONTROL_B_RST 8'h00
// Timing
`define BITS_PER_CONV 4'hb
`define ABORT_PERIODS 2'h2
`define RC_DIVISOR 7'h10
`define DIV_W 7
`endif

// ==== conv_pkg.sv ====
// Purpose: Types of the converter control
// Assumes: Nothing
// Notes: Constants live in conv_defines.svh
package conv_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_GAP = 2'b11
    } conv_state_type;
endpackage : conv_pkg

// ==== conv_period_gen.sv ====
// Purpose: Bit period enable pulse generator
// Assumes: One clock; rc_tick_in is a one-cycle pulse of the RC clock
// Notes: Counter restarts on clear_in
`timescale 1ns/100ps
`default_nettype none
`include "conv_defines.svh"
module conv_period_gen (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic [2:0] sel_in,
    input wire logic rc_tick_in,
    output logic period_out,
    output logic valid_sel_out
);
    logic [`DIV_W-1:0] cnt_q;
    logic [`DIV_W-1:0] cnt_d;
    logic [`DIV_W-1:0] limit;
    logic use_rc;
    logic step;
    logic wrap;

    // Divisor chosen by the clock code
    assign use_rc = (sel_in[1:0] == 2'b11);
    assign limit = (sel_in == 3'b001) ? 7'h07 :
                   (sel_in == 3'b101) ? 7'h0f :
                   (sel_in == 3'b010) ? 7'h1f :
                   (sel_in == 3'b110) ? 7'h3f :
                   `RC_DIVISOR - 7'h01;
    assign valid_sel_out = (sel_in != 3'b000) && (sel_in != 3'b100);
    assign step = use_rc ? rc_tick_in : 1'b1;
    assign wrap = step && (cnt_q >= limit);
    assign cnt_d = wrap ? '0 : cnt_q + (step ? 7'h01 : 7'h00);
    assign period_out = wrap && valid_sel_out;

    // Divider counter
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : conv_period_gen
`default_nettype wire

// ==== conv_control.sv ====
// Purpose: Control and registers of a 10-bit SAR converter
// Assumes: Avalon-MM slave, 25 MHz clock, analog core gives bit decisions
// Notes: Result words are captured at completion only
//
// Overview of operation
// - No conversion in sleep; internal reference off during sleep.
// - Channel field bits 6..2 routes internal nodes, codes 0-7 and 10-15.
// - Codes 8, 9 reserved; codes 16..23 connect no source.
// - Codes 24..28 select five pins; 29..31 large package pins.
// - Writing one to go bit starts conversion; reads one while busy.
// - Hardware clears go bit at completion; zero means idle.
// - Enable bit turns converter on; off draws no current.
// - Clock field picks divide 8,16,32,64 or RC/16; 000, 100 reserved.
// - Reference bit picks 4.096 V regulator at zero, 5 V at one.
// - Result high holds bits 9..8 low, upper bits zero, read-only.
// - Result low holds bits 7..0, read-only, unknown after reset.
// - Sampling capacitor is never discharged after conversion.
// - A conversion lasts eleven bit periods.
// - Done flag set at every completion; cleared only by software.
// - Abort keeps old result (the code still captures it when sleep or enable-off meets the last bit period); two periods before reacquisition.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "conv_defines.svh"
module conv_control (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic sleep_in,
    input wire logic rc_tick_in,
    input wire logic comparator_in,
    output logic [4:0] channel_select_out,
    output logic channel_valid_out,
    output logic sample_hold_out,
    output logic [9:0] trial_code_out,
    output logic converter_power_out,
    output logic analog_ldo_ref_on_out,
    output logic reference_select_out,
    output logic conv_done_flag_out,
    output logic conv_done_irq_enable_out
);
    conv_pkg::conv_state_type state_q;
    conv_pkg::conv_state_type state_d;
    logic [7:0] ctl_a_q;
    logic [7:0] ctl_b_q;
    logic [9:0] result_q;
    logic [9:0] sar_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] gap_cnt_q;
    logic flag_q;
    logic irq_en_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic period;
    logic sel_ok;
    logic access;
    logic wr_a, wr_b, wr_st;
    logic sw_go, sw_abort;
    logic last_bit, done, abort, running;
    logic [7:0] rd_mux;
    logic [9:0] trial;
    logic [9:0] decided;

    // Returns the mask bit for a given SAR step
    function automatic logic [9:0] step_mask(input logic [3:0] n);
        step_mask = 10'h200 >> n;
    endfunction : step_mask

    // Bus decode: one wait cycle then acknowledge
    assign access = (avs_read_in || avs_write_in) && !ack_q;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
    assign wr_a = access && avs_write_in && avs_byteenable_in[0] &&
                  ({avs_address_in[4:2], 2'b00} == {1'b0, `OFS_CONTROL_A});
    assign wr_b = access && avs_write_in && avs_byteenable_in[0] &&
                  ({avs_address_in[4:2], 2'b00} == {1'b0, `OFS_CONTROL_B});
    assign wr_st = access && avs_write_in && avs_byteenable_in[0] &&
                   ({avs_address_in[4:2], 2'b00} == 5'h10);

    // Go requests from software
    assign sw_go = wr_a && avs_writedata_in[`CA_GO_BIT] &&
                   ctl_a_q[`CA_ON_BIT] && avs_writedata_in[`CA_ON_BIT] &&
                   !sleep_in && sel_ok;
    assign sw_abort = wr_a && !avs_writedata_in[`CA_GO_BIT] && running;
    assign running = (state_q == conv_pkg::ST_CONV);
    assign last_bit = period && (bit_cnt_q == `BITS_PER_CONV - 4'h1);
    assign done = running && last_bit && !sw_abort;
    assign abort = running && (sw_abort || sleep_in ||
                   !ctl_a_q[`CA_ON_BIT]);

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            conv_pkg::ST_IDLE: begin
                if (sw_go) begin
                    state_d = conv_pkg::ST_CONV;
                end
            end
            conv_pkg::ST_CONV: begin
                if (abort) begin
                    state_d = conv_pkg::ST_GAP;
                end else if (done) begin
                    state_d = conv_pkg::ST_IDLE;
                end
            end
            conv_pkg::ST_GAP: begin
                if (gap_cnt_q == `ABORT_PERIODS) begin
                    state_d = conv_pkg::ST_IDLE;
                end
            end
            default: state_d = conv_pkg::ST_IDLE;
        endcase
    end

    // Bit period generator, restarted at each start
    conv_period_gen u_period (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(sw_go),
        .sel_in(ctl_b_q[`CB_CLK_MSB:`CB_CLK_LSB]),
        .rc_tick_in(rc_tick_in),
        .period_out(period),
        .valid_sel_out(sel_ok)
    );

    // State, counters and SAR register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q <= conv_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            gap_cnt_q <= 2'h0;
            sar_q <= 10'h000;
        end else begin
            state_q <= state_d;
            if (sw_go) begin
                bit_cnt_q <= 4'h0;
                sar_q <= 10'h000;
            end else if (running && period) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (bit_cnt_q != 4'h0 && bit_cnt_q < `BITS_PER_CONV) begin
                    sar_q <= decided;
                end
            end
            if (state_q != conv_pkg::ST_GAP) begin
                gap_cnt_q <= 2'h0;
            end else if (period) begin
                gap_cnt_q <= gap_cnt_q + 2'h1;
            end
        end
    end

    // Trial code: kept bits plus the bit under test
    assign trial = (bit_cnt_q == 4'h0 || bit_cnt_q > 4'ha) ? sar_q :
                   sar_q | step_mask(bit_cnt_q - 4'h1);
    // Trial after the comparator decision; last bit must be decided too
    assign decided = comparator_in ? trial :
                     (trial & ~step_mask(bit_cnt_q - 4'h1));

    // Result words captured together at completion only
    always_ff @(posedge clk_in) begin
        if (done) begin
            result_q <= decided;
        end
    end

    // Control registers; go bit mirrors the busy state
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctl_a_q <= `CONTROL_A_RST;
            ctl_b_q <= `CONTROL_B_RST;
        end else begin
            if (wr_a) begin
                ctl_a_q <= {1'b0, avs_writedata_in[6:2], 1'b0,
                            avs_writedata_in[0]};
            end
            if (wr_b) begin
                ctl_b_q <= {1'b0, avs_writedata_in[6:4], 3'b000,
                            avs_writedata_in[0]};
            end
        end
    end

    // Done flag and its enable; set wins over clear
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (done) begin
                flag_q <= 1'b1;
            end else if (wr_st && !avs_writedata_in[`ST_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
            if (wr_st) begin
                irq_en_q <= avs_writedata_in[`ST_IE_BIT];
            end
        end
    end

    // Read data mux, unmapped reads zero
    assign rd_mux = (avs_address_in == 5'h00) ?
                        {ctl_a_q[7:2], running, ctl_a_q[0]} :
                    (avs_address_in == 5'h04) ? ctl_b_q :
                    (avs_address_in == 5'h08) ?
                        {6'h00, result_q[9:8]} :
                    (avs_address_in == 5'h0c) ? result_q[7:0] :
                    (avs_address_in == 5'h10) ? {6'h00, irq_en_q, flag_q} :
                    8'h00;

    // Bus answer register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= access;
            if (access && avs_read_in) begin
                rdata_q <= {24'h000000, rd_mux};
            end
        end
    end
    assign avs_readdata_out = rdata_q;

    // Analog side controls
    assign channel_select_out = ctl_a_q[`CA_CHS_MSB:`CA_CHS_LSB];
    assign channel_valid_out = !(channel_select_out[4:3] == 2'b10) &&
                               !(channel_select_out[4:1] == 4'b0100);
    assign sample_hold_out = running && bit_cnt_q != 4'h0;
    assign trial_code_out = trial;
    assign converter_power_out = ctl_a_q[`CA_ON_BIT] && !sleep_in;
    assign analog_ldo_ref_on_out = !sleep_in;
    assign reference_select_out = ctl_b_q[`CB_REF_BIT];
    assign conv_done_flag_out = flag_q;
    assign conv_done_irq_enable_out = irq_en_q;

    // Checks
    AST_GO_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !ctl_a_q[`CA_ON_BIT] |=> !running)
        else $error("start while off");
    AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sleep_in |=> !running)
        else $error("converting in sleep");
    AST_DONE_FLAG: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done |=> flag_q && !running)
        else $error("flag not set at done");
    AST_RESULT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done |=> result_q == $past(decided))
        else $error("result not captured");
    AST_KEEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        abort |=> $stable(result_q))
        else $error("result changed on abort");
    AST_GAP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        abort |=> state_q == conv_pkg::ST_GAP)
        else $error("no gap after abort");
    AST_HIGH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        avs_address_in == 5'h08 && access && avs_read_in
        |=> avs_readdata_out[31:2] == 30'h0)
        else $error("high bits not zero");
    AST_POWER: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !ctl_a_q[0] |-> !converter_power_out)
        else $error("power while off");
endmodule : conv_control
`default_nettype wire

// ==== sar_analog_model.sv ====
// Purpose: Behavioural analog front end: hold capacitor, comparator
// Assumes: Trial code is stable during each held bit period
// Notes: Comparator shows a toggling pattern when it is not being sampled
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [9:0] level_in,
    input wire logic [9:0] trial_code_in,
    input wire logic sample_hold_in,
    input wire logic power_in,
    output logic comparator_out
);
    logic [9:0] held_q;
    logic toggle_q;

    // Track while acquiring, freeze while holding; never discharged
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            held_q <= 10'h000;
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= ~toggle_q;
            if (!sample_hold_in) begin
                held_q <= level_in;
            end
        end
    end

    // Comparator meaningful only when powered and holding
    assign comparator_out = (power_in && sample_hold_in) ?
        (trial_code_in <= held_q) : toggle_q;
endmodule : sar_analog_model
`default_nettype wire

// ==== sar_adc_control_test.sv ====
// Purpose: Self-checking bench of the converter control block
// Assumes: Avalon slave answers after one wait cycle
// Notes: RC tick pulses every 4 clocks
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control_test;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [4:0] avs_address_in = 5'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic sleep_in = 1'b0;
    logic rc_tick_in = 1'b0;
    logic comparator_in;
    logic [4:0] channel_select_out;
    logic channel_valid_out, sample_hold_out, converter_power_out;
    logic [9:0] trial_code_out;
    logic analog_ldo_ref_on_out, reference_select_out;
    logic conv_done_flag_out, conv_done_irq_enable_out;
    logic [9:0] level = 10'h000;
    logic [1:0] rc_cnt = 2'h0;
    int cyc = 0;
    int miscompares = 0;
    int checks_done = 0;

    conv_control i_conv_control (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .sleep_in(sleep_in),
        .rc_tick_in(rc_tick_in), .comparator_in(comparator_in),
        .channel_select_out(channel_select_out),
        .channel_valid_out(channel_valid_out),
        .sample_hold_out(sample_hold_out), .trial_code_out(trial_code_out),
        .converter_power_out(converter_power_out),
        .analog_ldo_ref_on_out(analog_ldo_ref_on_out),
        .reference_select_out(reference_select_out),
        .conv_done_flag_out(conv_done_flag_out),
        .conv_done_irq_enable_out(conv_done_irq_enable_out));
    sar_analog_model i_sar_analog_model (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .level_in(level),
        .trial_code_in(trial_code_out), .sample_hold_in(sample_hold_out),
        .power_in(converter_power_out), .comparator_out(comparator_in));

    // Clock, RC tick and cycle counter with hang limit
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        rc_cnt <= rc_cnt + 2'h1;
        rc_tick_in <= (rc_cnt == 2'h3);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input string w, input logic [9:0] e,
                         input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask : check

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        if (n >= 100) begin
            miscompares++;
            $display("mismatch bus answer expected 0 seen 1");
        end
        q = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e,
                      input string w);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(w, {2'h0, e}, {2'h0, q});
    endtask : rd

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        logic [2:0] codes[6];
        int divs[6];
        int t0;
        codes = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        divs = '{8, 16, 32, 64, 64, 64};
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(5'h00, 8'h00, "ctl_a reset");
        rd(5'h04, 8'h00, "ctl_b reset");
        check("ref sel", 10'h0, {9'h0, reference_select_out});
        for (int c = 0; c < 32; c++) begin
            wr(5'h00, 8'(c << 2));
            check("chan", 10'(c * 2 + !(c == 8 || c == 9 || (c >= 16 && c < 24))),
                  {4'h0, channel_select_out, channel_valid_out});
        end
        wr(5'h00, 8'h62);
        rd(5'h00, 8'h60, "go while off");
        check("power off", 10'h0, {9'h0, converter_power_out});
        wr(5'h04, 8'h8f);
        rd(5'h04, 8'h01, "ctl_b mask");
        check("ref sel", 10'h1, {9'h0, reference_select_out});
        wr(5'h00, 8'h61);
        wr(5'h00, 8'h63);
        rd(5'h00, 8'h61, "go reserved clk");
        for (int i = 0; i < 6; i++) begin
            level <= 10'(10'h155 + i * 97);
            wr(5'h04, {1'b0, codes[i], 4'h0});
            wr(5'h10, 8'h00);
            repeat (20) @(posedge clk_in);
            check("power on", 10'h1, {9'h0, converter_power_out});
            wr(5'h00, 8'h63);
            t0 = cyc;
            rd(5'h00, 8'h63, "go busy");
            while (conv_done_flag_out !== 1'b1 && cyc - t0 < 2000)
                @(posedge clk_in);
            check("conv time ok", 10'h1,
                  10'(cyc - t0 >= 11 * divs[i] - 4 &&
                      cyc - t0 <= 11 * divs[i]));
            rd(5'h00, 8'h61, "go done");
            rd(5'h08, {6'h00, level[9:8]}, "res hi");
            rd(5'h0c, level[7:0], "res lo");
            check("flag", 10'h1, {9'h0, conv_done_flag_out});
        end
        wr(5'h10, 8'h02);
        check("flag clr ie", 10'h1,
              {8'h0, conv_done_flag_out, conv_done_irq_enable_out});
        wr(5'h04, 8'h10);
        level <= 10'h0aa;
        repeat (20) @(posedge clk_in);
        wr(5'h00, 8'h63);
        repeat (30) @(posedge clk_in);
        wr(5'h00, 8'h61);
        repeat (100) @(posedge clk_in);
        rd(5'h0c, 8'h3a, "abort lo");
        check("abort flag", 10'h0, {9'h0, conv_done_flag_out});
        wr(5'h08, 8'hff);
        wr(5'h0c, 8'h55);
        rd(5'h08, 8'h03, "ro hi");
        rd(5'h0c, 8'h3a, "ro lo");
        wr(5'h14, 8'hff);
        rd(5'h14, 8'h00, "unmapped");
        sleep_in <= 1'b1;
        wr(5'h00, 8'h63);
        check("sleep pwr ldo", 10'h0,
              {8'h0, converter_power_out, analog_ldo_ref_on_out});
        rd(5'h00, 8'h61, "go sleep");
        sleep_in <= 1'b0;
        complete_run();
    end
endmodule : sar_adc_control_test
`default_nettype wire
